// [pkg/qrr_pkg.sv]
package qrr_pkg;
  // ------------------------------------------------------------
  // Register addresses on the link
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_QUERY_LO = 8'h20;
  localparam logic [7:0] ADDR_QUERY_HI = 8'h27;
  localparam logic [7:0] ADDR_INFO     = 8'h23;
  localparam logic [7:0] ADDR_LIST     = 8'h24;
  localparam logic [7:0] ADDR_DAC      = 8'h25;
  localparam logic [7:0] ADDR_DRAIN    = 8'h26;
  // Data bytes that follow the address byte
  localparam logic [2:0] LEN_INFO      = 3'h1;
  localparam logic [2:0] LEN_LIST      = 3'h3;
  localparam logic [2:0] LEN_DAC       = 3'h1;
  localparam logic [2:0] LEN_DRAIN     = 3'h7;
  localparam logic [2:0] LEN_OTHER     = 3'h1;
  // ------------------------------------------------------------
  // Selector codes and fields
  // ------------------------------------------------------------
  localparam logic [2:0] INFO_SERIAL   = 3'h0;
  localparam logic [2:0] INFO_HW_REV   = 3'h1;
  localparam logic [2:0] INFO_FW_REV   = 3'h2;
  localparam logic [2:0] INFO_DATE     = 3'h3;
  localparam logic [1:0] LIST_FREQ     = 2'h0;
  localparam logic [1:0] LIST_DWELL    = 2'h1;
  localparam logic [1:0] LIST_AMP      = 2'h2;
  localparam logic [15:0] LIST_MAX_IDX = 16'h03ff;
  localparam int LIST_IDX_MSB   = 15;
  localparam int LIST_PARAM_LSB = 22;
  localparam int INFO_SEL_MSB   = 2;
  localparam int DAC_SEL_BIT    = 0;
  localparam int AMP_SIGN_BIT   = 15;
  localparam logic [63:0] RESULT_RESET = 64'h0;
  // ------------------------------------------------------------
  // Host command registers
  // ------------------------------------------------------------
  localparam logic [7:0] HREG_CMD    = 8'h00;
  localparam logic [7:0] HREG_ARG    = 8'h04;
  localparam logic [7:0] HREG_RES_LO = 8'h08;
  localparam logic [7:0] HREG_RES_HI = 8'h0c;
  localparam logic [7:0] HREG_STATUS = 8'h10;
  localparam int CMD_LEN_LSB = 8;
  localparam int CMD_USB_BIT = 16;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ          = 50_000_000;
  localparam int SPI_HZ          = 5_000_000;
  localparam int SPI_HALF_CYCLES = CLK_HZ / (2 * SPI_HZ);
  localparam int CS_SETUP_NS     = 1000;
  localparam int BYTE_GAP_NS     = 1000;
  localparam int CMD_GAP_US      = 500;
  localparam int CS_SETUP_CYCLES =
    (CS_SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int BYTE_GAP_CYCLES =
    (BYTE_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CMD_GAP_CYCLES  = CMD_GAP_US * (CLK_HZ / 1_000_000);
endpackage

// [pkg/qrr_link_if.sv]
`timescale 1ns/1ns
interface qrr_link_if;
  logic        spiCsN;
  logic        spiClk;
  logic        spiMosi;
  logic        spiMiso;
  logic        usbWrite;
  logic [63:0] usbWord;
  logic        usbValid;
  logic [63:0] usbResult;
  modport device (input spiCsN, spiClk, spiMosi, usbWrite, usbWord,
                  output spiMiso, usbValid, usbResult);
  modport host (output spiCsN, spiClk, spiMosi, usbWrite, usbWord,
                input spiMiso, usbValid, usbResult);
endinterface

// [rtl/qrr_device.sv]
`timescale 1ns/1ns
module qrr_device #(
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001, // Arbitrary
  parameter logic [31:0] HW_REVISION   = 32'h3f80_0000, // Arbitrary
  parameter logic [31:0] FW_REVISION   = 32'h3f80_0000, // Arbitrary
  parameter logic [7:0]  MFG_YEAR      = 8'h01,
  parameter logic [7:0]  MFG_MONTH     = 8'h01,
  parameter logic [7:0]  MFG_DAY       = 8'h01,
  parameter logic [7:0]  MFG_HOUR      = 8'h00,
  parameter int          LIST_DEPTH    = 1024
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  qrr_link_if.device                         link,
  input  wire logic                          listWrite,
  input  wire logic [1:0]                    listParam,
  input  wire logic [$clog2(LIST_DEPTH)-1:0] listIndex,
  input  wire logic [63:0]                   listData,
  input  wire logic [15:0]                   levelingLoopDac,
  input  wire logic [15:0]                   loBandAmpDac
);
  localparam int IW = $clog2(LIST_DEPTH);

  // ------------------------------------------------------------
  // List point storage
  // ------------------------------------------------------------
  logic [63:0] freqMem  [LIST_DEPTH];
  logic [31:0] dwellMem [LIST_DEPTH];
  logic [15:0] ampMem   [LIST_DEPTH];

  always_ff @(posedge clk) begin
    if (listWrite) begin
      if (listParam == qrr_pkg::LIST_FREQ) begin
        freqMem[listIndex] <= listData;
      end else if (listParam == qrr_pkg::LIST_DWELL) begin
        dwellMem[listIndex] <= listData[31:0];
      end else if (listParam == qrr_pkg::LIST_AMP) begin
        ampMem[listIndex] <= listData[15:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Query decode
  // ------------------------------------------------------------
  function automatic logic [2:0] dataLength(input logic [7:0] a);
    if (a == qrr_pkg::ADDR_INFO) begin
      return qrr_pkg::LEN_INFO;
    end else if (a == qrr_pkg::ADDR_LIST) begin
      return qrr_pkg::LEN_LIST;
    end else if (a == qrr_pkg::ADDR_DAC) begin
      return qrr_pkg::LEN_DAC;
    end else if (a == qrr_pkg::ADDR_DRAIN) begin
      return qrr_pkg::LEN_DRAIN;
    end else begin
      return qrr_pkg::LEN_OTHER;
    end
  endfunction

  function automatic logic isQuery(input logic [7:0] a);
    return (a >= qrr_pkg::ADDR_QUERY_LO) && (a <= qrr_pkg::ADDR_QUERY_HI)
           && (a != qrr_pkg::ADDR_DRAIN);
  endfunction

  function automatic logic [63:0] runQuery(input logic [7:0]  a,
                                           input logic [23:0] v);
    logic [15:0]   idx;
    logic [IW-1:0] slot;
    logic [63:0]   res;
    idx  = v[qrr_pkg::LIST_IDX_MSB:0];
    slot = idx[IW-1:0];
    res  = qrr_pkg::RESULT_RESET;
    if (a == qrr_pkg::ADDR_INFO) begin
      case (v[qrr_pkg::INFO_SEL_MSB:0])
        qrr_pkg::INFO_SERIAL: res = {32'h0, SERIAL_NUMBER};
        qrr_pkg::INFO_HW_REV: res = {32'h0, HW_REVISION};
        qrr_pkg::INFO_FW_REV: res = {32'h0, FW_REVISION};
        qrr_pkg::INFO_DATE:   res = {32'h0, MFG_YEAR, MFG_MONTH,
                                     MFG_DAY, MFG_HOUR};
        default:              res = qrr_pkg::RESULT_RESET;
      endcase
    end else if (a == qrr_pkg::ADDR_LIST) begin
      // Out-of-range index or invalid parameter answers zero
      if (idx <= qrr_pkg::LIST_MAX_IDX && 32'(idx) < LIST_DEPTH) begin
        case (v[qrr_pkg::LIST_PARAM_LSB +: 2])
          qrr_pkg::LIST_FREQ:  res = freqMem[slot];
          qrr_pkg::LIST_DWELL: res = {32'h0, dwellMem[slot]};
          qrr_pkg::LIST_AMP:   res = {48'h0, ampMem[slot]};
          default:             res = qrr_pkg::RESULT_RESET;
        endcase
      end
    end else if (a == qrr_pkg::ADDR_DAC) begin
      res = {48'h0, v[qrr_pkg::DAC_SEL_BIT] ? loBandAmpDac
                                            : levelingLoopDac};
    end
    return res;
  endfunction

  // ------------------------------------------------------------
  // Link engine state
  // ------------------------------------------------------------
  logic        csPrev_r,  csPrev_nxt;
  logic        sclkPrev_r, sclkPrev_nxt;
  logic [2:0]  bitCnt_r,  bitCnt_nxt;
  logic [2:0]  byteIdx_r, byteIdx_nxt;
  logic [2:0]  need_r,    need_nxt;
  logic        busy_r,    busy_nxt;
  logic [7:0]  addr_r,    addr_nxt;
  logic [7:0]  inByte_r,  inByte_nxt;
  logic [23:0] acc_r,     acc_nxt;
  logic [63:0] outShift_r, outShift_nxt;
  logic        miso_r,    miso_nxt;
  logic [63:0] resBuf_r,  resBuf_nxt;
  logic        usbValid_r, usbValid_nxt;

  always_comb begin
    logic [7:0] byteNow;
    logic [7:0] usbAddr;
    logic [23:0] usbArg;
    byteNow      = {inByte_r[6:0], link.spiMosi};
    usbAddr      = link.usbWord[63:56];
    // USB data bytes are left-aligned; right-align them as over SPI
    usbArg       = link.usbWord[55:32] >>
                   (5'(3'h3 - dataLength(usbAddr)) * 5'd8);
    csPrev_nxt   = link.spiCsN;
    sclkPrev_nxt = link.spiClk;
    bitCnt_nxt   = bitCnt_r;
    byteIdx_nxt  = byteIdx_r;
    need_nxt     = need_r;
    busy_nxt     = busy_r;
    addr_nxt     = addr_r;
    inByte_nxt   = inByte_r;
    acc_nxt      = acc_r;
    outShift_nxt = outShift_r;
    miso_nxt     = miso_r;
    resBuf_nxt   = resBuf_r;
    usbValid_nxt = 1'b0;
    if (link.spiCsN) begin
      busy_nxt = 1'b0;
    end else if (csPrev_r) begin
      // Frame opens: load the staged result for shifting out
      bitCnt_nxt   = 3'h0;
      byteIdx_nxt  = 3'h0;
      acc_nxt      = 24'h0;
      busy_nxt     = 1'b1;
      outShift_nxt = resBuf_r;
      miso_nxt     = resBuf_r[63];
    end else if (busy_r) begin
      if (link.spiClk && !sclkPrev_r && (bitCnt_r != 3'h0 ||
          byteIdx_r != 3'h0)) begin
        outShift_nxt = {outShift_r[62:0], 1'b0};
        miso_nxt     = outShift_r[62];
      end else if (!link.spiClk && sclkPrev_r) begin
        inByte_nxt = byteNow;
        bitCnt_nxt = bitCnt_r + 3'h1;
        if (bitCnt_r == 3'h7) begin
          byteIdx_nxt = byteIdx_r + 3'h1;
          if (byteIdx_r == 3'h0) begin
            addr_nxt = byteNow;
            need_nxt = dataLength(byteNow);
          end else begin
            acc_nxt = {acc_r[15:0], byteNow};
            if (byteIdx_r == need_r) begin
              busy_nxt = 1'b0;
              if (addr_r == qrr_pkg::ADDR_DRAIN) begin
                resBuf_nxt = qrr_pkg::RESULT_RESET;
              end else if (isQuery(addr_r)) begin
                resBuf_nxt = runQuery(addr_r, {acc_r[15:0], byteNow});
              end
            end
          end
        end
      end
    end
    // USB queries win a same-cycle clash; drain is not honoured there
    if (link.usbWrite && isQuery(usbAddr)) begin
      resBuf_nxt   = runQuery(usbAddr, usbArg);
      usbValid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      csPrev_r   <= 1'b1;
      sclkPrev_r <= 1'b0;
      bitCnt_r   <= 3'h0;
      byteIdx_r  <= 3'h0;
      need_r     <= 3'h0;
      busy_r     <= 1'b0;
      addr_r     <= 8'h0;
      inByte_r   <= 8'h0;
      acc_r      <= 24'h0;
      outShift_r <= qrr_pkg::RESULT_RESET;
      miso_r     <= 1'b0;
      resBuf_r   <= qrr_pkg::RESULT_RESET;
      usbValid_r <= 1'b0;
    end else begin
      csPrev_r   <= csPrev_nxt;
      sclkPrev_r <= sclkPrev_nxt;
      bitCnt_r   <= bitCnt_nxt;
      byteIdx_r  <= byteIdx_nxt;
      need_r     <= need_nxt;
      busy_r     <= busy_nxt;
      addr_r     <= addr_nxt;
      inByte_r   <= inByte_nxt;
      acc_r      <= acc_nxt;
      outShift_r <= outShift_nxt;
      miso_r     <= miso_nxt;
      resBuf_r   <= resBuf_nxt;
      usbValid_r <= usbValid_nxt;
    end
  end

  assign link.spiMiso   = miso_r;
  assign link.usbValid  = usbValid_r;
  assign link.usbResult = resBuf_r;
endmodule // qrr_device

// [rtl/qrr_host.sv]
`timescale 1ns/1ns
module qrr_host #(
  parameter int CMD_GAP_CYCLES = qrr_pkg::CMD_GAP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  qrr_link_if.host         link,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata
);
  typedef enum logic [5:0] {
    H_IDLE  = 6'b000001,
    H_USB   = 6'b000010,
    H_SETUP = 6'b000100,
    H_BIT   = 6'b001000,
    H_GAP   = 6'b010000,
    H_COOL  = 6'b100000
  } qrr_hstate_e;

  qrr_hstate_e state_r, state_nxt;
  logic [16:0] cmd_r,    cmd_nxt;
  logic [31:0] arg_r,    arg_nxt;
  logic [63:0] result_r, result_nxt;
  logic [15:0] cnt_r,    cnt_nxt;
  logic [2:0]  bitCnt_r, bitCnt_nxt;
  logic [2:0]  byteCnt_r, byteCnt_nxt;
  logic [7:0]  txByte_r, txByte_nxt;
  logic [63:0] rx_r,     rx_nxt;
  logic        csN_r,    csN_nxt;
  logic        sclk_r,   sclk_nxt;
  logic        mosi_r,   mosi_nxt;
  logic        usbWr_r,  usbWr_nxt;
  logic [63:0] usbWord_r, usbWord_nxt;
  logic [31:0] rdata_r,  rdata_nxt;

  // Data bytes right-aligned; byte k counts from the address byte
  function automatic logic [7:0] dataByte(input logic [31:0] a,
                                          input logic [2:0] len,
                                          input logic [2:0] k);
    logic [55:0] sh;
    sh = {24'h0, a} >> (6'(len - k) * 6'd8);
    return sh[7:0];
  endfunction

  always_comb begin
    logic [7:0] cAddr;
    logic [2:0] cLen;
    cAddr       = cmd_r[7:0];
    cLen        = cmd_r[qrr_pkg::CMD_LEN_LSB +: 3];
    state_nxt   = state_r;
    cmd_nxt     = cmd_r;
    arg_nxt     = arg_r;
    result_nxt  = result_r;
    cnt_nxt     = cnt_r;
    bitCnt_nxt  = bitCnt_r;
    byteCnt_nxt = byteCnt_r;
    txByte_nxt  = txByte_r;
    rx_nxt      = rx_r;
    csN_nxt     = csN_r;
    sclk_nxt    = sclk_r;
    mosi_nxt    = mosi_r;
    usbWr_nxt   = 1'b0;
    usbWord_nxt = usbWord_r;
    rdata_nxt   = 32'h0;
    // ------------------------------------------------------------
    // Command registers
    // ------------------------------------------------------------
    if (regRead) begin
      if (regAddr == qrr_pkg::HREG_CMD) begin
        rdata_nxt = {15'h0, cmd_r};
      end else if (regAddr == qrr_pkg::HREG_ARG) begin
        rdata_nxt = arg_r;
      end else if (regAddr == qrr_pkg::HREG_RES_LO) begin
        rdata_nxt = result_r[31:0];
      end else if (regAddr == qrr_pkg::HREG_RES_HI) begin
        rdata_nxt = result_r[63:32];
      end else if (regAddr == qrr_pkg::HREG_STATUS) begin
        rdata_nxt = {31'h0, state_r != H_IDLE};
      end
    end
    if (regWrite && regAddr == qrr_pkg::HREG_ARG && state_r == H_IDLE) begin
      arg_nxt = regWdata;
    end
    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    case (state_r)
      H_IDLE: begin
        if (regWrite && regAddr == qrr_pkg::HREG_CMD) begin
          cmd_nxt = regWdata[16:0];
          if (regWdata[qrr_pkg::CMD_USB_BIT]) begin
            // Drain has no meaning over USB, so it is dropped
            if (regWdata[7:0] != qrr_pkg::ADDR_DRAIN) begin
              usbWr_nxt   = 1'b1;
              usbWord_nxt = {regWdata[7:0],
                             {24'h0, arg_r} << (6'(3'h7 - regWdata[10:8])
                                                * 6'd8)};
              state_nxt   = H_USB;
            end
          end else begin
            csN_nxt   = 1'b0;
            cnt_nxt   = 16'(qrr_pkg::CS_SETUP_CYCLES - 1);
            state_nxt = H_SETUP;
          end
        end
      end
      H_USB: begin
        // Configuration writes get no answer, so do not wait on them
        if (link.usbValid || cAddr < qrr_pkg::ADDR_QUERY_LO ||
            cAddr > qrr_pkg::ADDR_QUERY_HI) begin
          if (link.usbValid) begin
            result_nxt = link.usbResult;
          end
          state_nxt = H_IDLE;
        end
      end
      H_SETUP, H_GAP: begin
        if (cnt_r == 16'h0) begin
          if (byteCnt_r == 3'h0) begin
            txByte_nxt = cAddr;
          end else if (cAddr == qrr_pkg::ADDR_DRAIN) begin
            txByte_nxt = 8'h00;
          end else begin
            txByte_nxt = dataByte(arg_r, cLen, byteCnt_r);
          end
          bitCnt_nxt = 3'h0;
          cnt_nxt    = 16'h0;
          state_nxt  = H_BIT;
        end else begin
          cnt_nxt = cnt_r - 16'h1;
        end
      end
      H_BIT: begin
        if (cnt_r != 16'h0) begin
          cnt_nxt = cnt_r - 16'h1;
        end else if (!sclk_r) begin
          sclk_nxt = 1'b1;
          mosi_nxt = txByte_r[7];
          cnt_nxt  = 16'(qrr_pkg::SPI_HALF_CYCLES - 1);
        end else begin
          sclk_nxt   = 1'b0;
          rx_nxt     = {rx_r[62:0], link.spiMiso};
          txByte_nxt = {txByte_r[6:0], 1'b0};
          bitCnt_nxt = bitCnt_r + 3'h1;
          cnt_nxt    = 16'(qrr_pkg::SPI_HALF_CYCLES - 1);
          if (bitCnt_r == 3'h7) begin
            byteCnt_nxt = byteCnt_r + 3'h1;
            if (byteCnt_r == cLen) begin
              // Select stays low one more cycle so the last bit is taken
              byteCnt_nxt = 3'h0;
              cnt_nxt     = 16'(CMD_GAP_CYCLES - 1);
              state_nxt   = H_COOL;
              if (cAddr == qrr_pkg::ADDR_DRAIN) begin
                result_nxt = {rx_r[62:0], link.spiMiso};
              end
            end else begin
              cnt_nxt   = 16'(qrr_pkg::BYTE_GAP_CYCLES - 1);
              state_nxt = H_GAP;
            end
          end
        end
      end
      H_COOL: begin
        // Device needs time to act before the next command
        csN_nxt = 1'b1;
        if (cnt_r == 16'h0) begin
          state_nxt = H_IDLE;
        end else begin
          cnt_nxt = cnt_r - 16'h1;
        end
      end
      default: state_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r   <= H_IDLE;
      cmd_r     <= 17'h0;
      arg_r     <= 32'h0;
      result_r  <= qrr_pkg::RESULT_RESET;
      cnt_r     <= 16'h0;
      bitCnt_r  <= 3'h0;
      byteCnt_r <= 3'h0;
      txByte_r  <= 8'h0;
      rx_r      <= 64'h0;
      csN_r     <= 1'b1;
      sclk_r    <= 1'b0;
      mosi_r    <= 1'b0;
      usbWr_r   <= 1'b0;
      usbWord_r <= 64'h0;
      rdata_r   <= 32'h0;
    end else begin
      state_r   <= state_nxt;
      cmd_r     <= cmd_nxt;
      arg_r     <= arg_nxt;
      result_r  <= result_nxt;
      cnt_r     <= cnt_nxt;
      bitCnt_r  <= bitCnt_nxt;
      byteCnt_r <= byteCnt_nxt;
      txByte_r  <= txByte_nxt;
      rx_r      <= rx_nxt;
      csN_r     <= csN_nxt;
      sclk_r    <= sclk_nxt;
      mosi_r    <= mosi_nxt;
      usbWr_r   <= usbWr_nxt;
      usbWord_r <= usbWord_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign link.spiCsN   = csN_r;
  assign link.spiClk   = sclk_r;
  assign link.spiMosi  = mosi_r;
  assign link.usbWrite = usbWr_r;
  assign link.usbWord  = usbWord_r;
  assign regRdata      = rdata_r;
endmodule // qrr_host

// [tb/qrr_assertions.sv]
`timescale 1ns/1ns
module qrr_assertions (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        spiCsN,
  input wire logic        spiClk,
  input wire logic        spiMosi,
  input wire logic        spiMiso,
  input wire logic        usbWrite,
  input wire logic [63:0] usbWord,
  input wire logic        usbValid,
  input wire logic [63:0] usbResult
);
  // ----------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------
  logic [6:0]  bitCnt_r;
  logic [6:0]  bitCnt_nxt;
  logic [63:0] bits_r;
  logic [63:0] bits_nxt;
  logic        clkPrev_r;
  always_comb begin
    bitCnt_nxt = bitCnt_r;
    bits_nxt   = bits_r;
    if (spiCsN) begin
      bitCnt_nxt = 7'h0;
    end else if (clkPrev_r && !spiClk) begin
      bitCnt_nxt = bitCnt_r + 7'h1;
      bits_nxt   = {bits_r[62:0], spiMosi};
    end
  end
  always_ff @(posedge clk) begin
    clkPrev_r <= reset ? 1'b0 : spiClk;
    bitCnt_r  <= reset ? 7'h0 : bitCnt_nxt;
    bits_r    <= bits_nxt;
  end
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence usbQuery;
    usbWrite && usbWord[63:56] >= qrr_pkg::ADDR_QUERY_LO &&
    usbWord[63:56] <= qrr_pkg::ADDR_QUERY_HI &&
    usbWord[63:56] != qrr_pkg::ADDR_DRAIN;
  endsequence
  sequence linkQuiet;
    spiCsN [*3] ##0 !usbValid && !$past(usbValid);
  endsequence
  usb_answer_a: assert property (usbQuery |=> usbValid)
    else $error("no usbValid after a query write");
  valid_cause_a: assert property (usbValid |-> $past(usbWrite))
    else $error("usbValid without a query write");
  dac_zero_a: assert property (
    usbWrite && usbWord[63:56] == qrr_pkg::ADDR_DAC
    |-> ##2 usbResult[63:16] == 48'h0)
    else $error("DAC result not zero above bit 15");
  drain_usb_a: assert property (
    !(usbWrite && usbWord[63:56] == qrr_pkg::ADDR_DRAIN))
    else $error("drain sent over USB");
  result_hold_a: assert property (linkQuiet |-> $stable(usbResult))
    else $error("staged result changed with no query");
  clk_idle_a: assert property (spiCsN |-> !spiClk)
    else $error("serial clock outside chip select");
  cs_setup_a: assert property ($fell(spiCsN) |-> !spiClk [*8])
    else $error("serial clock too soon after select");
  frame_len_a: assert property ($rose(spiCsN) |->
    bitCnt_r inside {7'h10, 7'h20, 7'h40})
    else $error("frame not a whole command");
  drain_zero_a: assert property (
    $rose(spiCsN) && bitCnt_r == 7'h40
    |-> bits_r == {qrr_pkg::ADDR_DRAIN, 56'h0})
    else $error("drain frame malformed");
  mosi_hold_a: assert property ($fell(spiClk) |-> $stable(spiMosi))
    else $error("data moved at sampling edge");
endmodule // qrr_assertions

// [tb/testbench.sv]
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [31:0] cmd;
    logic [31:0] arg;
    logic [63:0] mask;
    logic [63:0] exp;
  } qrr_row_s;
  localparam logic [63:0] LO32 = 64'h0000_0000_ffff_ffff;
  localparam logic [63:0] ALL  = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] FRQ  = 64'h0000_0ae9_f7bc_c000;
  logic        clk;
  logic        reset;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic        listWrite;
  logic [1:0]  listParam;
  logic [9:0]  listIndex;
  logic [63:0] listData;
  logic [15:0] levelingLoopDac;
  logic [15:0] loBandAmpDac;
  logic [63:0] res;
  int          failCount;
  int          checksDone;
  int          cycles;
  qrr_row_s    rows [0:14];
  qrr_link_if link ();
  // Identity values are arbitrary
  // Serial, year and hour keep their defaults: 1, 01 and 00
  qrr_device #(.HW_REVISION(32'h4000_0000), .FW_REVISION(32'h3fc0_0000),
    .MFG_MONTH(8'h0c), .MFG_DAY(8'h1f)) u_qrr_device (.clk(clk),
    .reset(reset), .link(link), .listWrite(listWrite),
    .listParam(listParam), .listIndex(listIndex), .listData(listData),
    .levelingLoopDac(levelingLoopDac), .loBandAmpDac(loBandAmpDac));
  // Short command gap keeps the run brief
  qrr_host #(.CMD_GAP_CYCLES(20)) u_qrr_host (.clk(clk), .reset(reset),
    .link(link), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
  qrr_assertions u_qrr_assertions (.clk(clk), .reset(reset),
    .spiCsN(link.spiCsN), .spiClk(link.spiClk), .spiMosi(link.spiMosi),
    .spiMiso(link.spiMiso), .usbWrite(link.usbWrite),
    .usbWord(link.usbWord), .usbValid(link.usbValid),
    .usbResult(link.usbResult));
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (failCount == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic wait_idle();
    logic [31:0] st;
    st = 32'h1;
    for (int n = 0; n < 20000 && st[0] !== 1'b0; n++) begin
      rd(qrr_pkg::HREG_STATUS, st);
    end
  endtask
  task automatic result(output logic [63:0] r);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(qrr_pkg::HREG_RES_LO, lo);
    rd(qrr_pkg::HREG_RES_HI, hi);
    r = {hi, lo};
  endtask
  task automatic query(input logic [31:0] c, input logic [31:0] a);
    wr(qrr_pkg::HREG_ARG, a);
    wr(qrr_pkg::HREG_CMD, c);
    wait_idle();
    // Over SPI the result only returns through a drain
    if (!c[16] && c[7:0] != qrr_pkg::ADDR_DRAIN) begin
      wr(qrr_pkg::HREG_CMD, 32'h0000_0726);
      wait_idle();
    end
  endtask
  task automatic lw(input logic [1:0] p, input logic [9:0] i,
                    input logic [63:0] d);
    @(posedge clk);
    listParam <= p;
    listIndex <= i;
    listData  <= d;
    listWrite <= 1'b1;
    @(posedge clk);
    listWrite <= 1'b0;
  endtask
  // ----------------------------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failCount++;
      give_verdict();
    end
  end
  initial begin
    reset = 1'b1;
    regAddr = 8'h0;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    listWrite = 1'b0;
    listParam = 2'h0;
    listIndex = 10'h0;
    listData = 64'h0;
    levelingLoopDac = 16'hbeef;
    loBandAmpDac = 16'h1357;
    failCount = 0;
    checksDone = 0;
    cycles = 0;
    rows[0]  = '{32'h10123, 32'h0, LO32, 64'h0000_0001};
    rows[1]  = '{32'h10123, 32'h1, LO32, 64'h4000_0000};
    rows[2]  = '{32'h10123, 32'h2, LO32, 64'h3fc0_0000};
    rows[3]  = '{32'h10123, 32'h3, LO32, 64'h010c_1f00};
    rows[4]  = '{32'h00123, 32'h0, LO32, 64'h0000_0001};
    rows[5]  = '{32'h00123, 32'h3, LO32, 64'h010c_1f00};
    rows[6]  = '{32'h10123, 32'h5, LO32, 64'h0};
    rows[7]  = '{32'h10125, 32'h0, ALL, 64'hbeef};
    rows[8]  = '{32'h00125, 32'h1, ALL, 64'h1357};
    rows[9]  = '{32'h10324, 32'h0003ff, ALL, FRQ};
    rows[10] = '{32'h10324, 32'h4003ff, LO32, 64'h1234_5678};
    rows[11] = '{32'h10324, 32'h8003ff, 64'hffff, 64'h8123};
    rows[12] = '{32'h00324, 32'h000000, ALL, 64'h0123_4567_89ab_cdef};
    rows[13] = '{32'h10324, 32'hc003ff, ALL, 64'h0};
    rows[14] = '{32'h10324, 32'h000400, ALL, 64'h0};
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    result(res);
    check(res, 64'h0);
    lw(2'h0, 10'h3ff, FRQ);
    lw(2'h1, 10'h3ff, 64'h1234_5678);
    lw(2'h2, 10'h3ff, 64'h8123);
    lw(2'h0, 10'h0, 64'h0123_4567_89ab_cdef);
    foreach (rows[i]) begin
      query(rows[i].cmd, rows[i].arg);
      result(res);
      check(res & rows[i].mask, rows[i].exp);
    end
    // Drain after a USB query still returns the shared buffer
    query(32'h10125, 32'h0);
    query(32'h00000726, 32'h0);
    result(res);
    check(res, 64'hbeef);
    query(32'h00000726, 32'h0);
    result(res);
    check(res, 64'h0);
    wr(qrr_pkg::HREG_CMD, 32'h0001_0726);
    rd(qrr_pkg::HREG_STATUS, res[31:0]);
    check({32'h0, res[31:0]}, 64'h0);
    rd(8'h14, res[31:0]);
    check({32'h0, res[31:0]}, 64'h0);
    give_verdict();
  end
endmodule // testbench
